// ---- verilog/lcd_command_slave.sv ----
// Purpose: Two-wire slave and command decoder of a segment LCD driver.
// Assumes: Open-drain data pin; the clock pin is input only.
// Notes: Display RAM is held here; a second port reads it for drive.
`timescale 1ns/1ps
`default_nettype none
module lcd_command_slave
	import lcd_cmd_pkg::*;
#(
	parameter int DIV_BASE = BLINK_DIV_BASE
)
(
	// Clock and reset
	input wire logic clk,
	input wire logic resetn,
	// Bus pins
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe_n,
	// Display RAM read port for the drive logic
	input wire logic [4:0] disp_addr,
	output logic [7:0] disp_data,
	// Mode settings
	output logic bias_half,
	output logic frame_160hz,
	output logic osc_run,
	output logic display_on,
	// Blinking
	output logic [1:0] blink_rate_bits,
	output logic blink_blank,
	// Supply and trim settings
	output logic pin_function_select,
	output logic voltage_adjust_enable,
	output logic [3:0] voltage_step_code,
	output logic bias_follower_amp,
	// Pointer state
	output logic [4:0] ram_pointer_bits
);
	// ==========================================================
	// Front end
	logic sda_s;
	logic scl_rise;
	logic scl_fall;
	logic start;
	logic stop;

	two_wire_sync u_sync
	(
		.clk(clk),
		.resetn(resetn),
		.scl_in(scl_in),
		.sda_in(sda_in),
		.sda_s(sda_s),
		.scl_rise(scl_rise),
		.scl_fall(scl_fall),
		.start(start),
		.stop(stop)
	);

	// ==========================================================
	// State
	state_t state_ff;
	kind_t kind_ff;
	logic [3:0] bit_cnt_ff;
	logic [7:0] shift_ff;
	logic [7:0] tx_ff;
	logic rw_ff;
	logic oe_n_ff;
	logic was_data_ff;
	logic [4:0] ptr_ff;
	logic [7:0] ram [RAM_DEPTH];
	logic [7:0] disp_data_ff;
	logic mode_en_ff;
	logic [7:0] nxt_tx;
	logic byte_done;
	logic ptr_inc;
	logic tx_ack_ok;
	logic is_addr;
	logic is_mode;
	logic is_blink;
	logic is_trim;

	// Locations above the top one read as zero.
	function automatic logic [7:0] ram_rd(input logic [4:0] a);
		ram_rd = (a <= RAM_LAST) ? ram[a] : 8'h00;
	endfunction

	assign nxt_tx = ram_rd(ptr_ff);
	assign byte_done = state_ff == ST_RX && scl_fall && !start && !stop
		&& bit_cnt_ff == BYTE_BITS;
	assign tx_ack_ok = state_ff == ST_TX_ACK && scl_rise && !sda_s
		&& !start && !stop;
	assign ptr_inc = tx_ack_ok || (state_ff == ST_RX_ACK && scl_fall
		&& !start && !stop && was_data_ff);
	assign is_addr = shift_ff[7:5] == OP_ADDR;
	assign is_mode = shift_ff[7:5] == OP_MODE
		&& !shift_ff[MODE_Z_BIT];
	assign is_blink = shift_ff[7:2] == OP_BLINK;
	assign is_trim = shift_ff[7:6] == OP_TRIM;

	// ==========================================================
	// Bit-level protocol
	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			state_ff <= ST_IDLE;
			bit_cnt_ff <= 4'h0;
			shift_ff <= 8'h00;
			tx_ff <= 8'h00;
			rw_ff <= 1'b0;
			oe_n_ff <= 1'b1;
		end
		else if (stop)
		begin
			state_ff <= ST_IDLE;
			oe_n_ff <= 1'b1;
		end
		else if (start)
		begin
			state_ff <= ST_ADDR;
			bit_cnt_ff <= 4'h0;
			oe_n_ff <= 1'b1;
		end
		else
		begin
			case (state_ff)
				ST_ADDR, ST_RX:
					if (scl_rise)
					begin
						shift_ff <= {shift_ff[6:0], sda_s};
						bit_cnt_ff <= bit_cnt_ff + 4'h1;
					end
					else if (scl_fall && bit_cnt_ff == BYTE_BITS)
					begin
						if (state_ff == ST_RX)
						begin
							oe_n_ff <= 1'b0;
							state_ff <= ST_RX_ACK;
						end
						else if (shift_ff[7:1] == DEV_ADDR)
						begin
							oe_n_ff <= 1'b0;
							rw_ff <= shift_ff[0];
							state_ff <= ST_ADDR_ACK;
						end
						else
							state_ff <= ST_IDLE;
					end
				ST_ADDR_ACK:
					if (scl_fall)
					begin
						bit_cnt_ff <= 4'h0;
						if (rw_ff)
						begin
							tx_ff <= nxt_tx;
							oe_n_ff <= nxt_tx[7];
							state_ff <= ST_TX;
						end
						else
						begin
							oe_n_ff <= 1'b1;
							state_ff <= ST_RX;
						end
					end
				ST_RX_ACK:
					if (scl_fall)
					begin
						oe_n_ff <= 1'b1;
						bit_cnt_ff <= 4'h0;
						state_ff <= ST_RX;
					end
				ST_TX:
					if (scl_rise)
						bit_cnt_ff <= bit_cnt_ff + 4'h1;
					else if (scl_fall && bit_cnt_ff == BYTE_BITS)
					begin
						oe_n_ff <= 1'b1;
						state_ff <= ST_TX_ACK;
					end
					else if (scl_fall)
					begin
						tx_ff <= {tx_ff[6:0], 1'b0};
						oe_n_ff <= tx_ff[6];
					end
				ST_TX_ACK:
					// A refused byte ends the read until the next frame.
					if (scl_rise && sda_s)
						state_ff <= ST_IDLE;
					else if (scl_fall)
					begin
						tx_ff <= nxt_tx;
						oe_n_ff <= nxt_tx[7];
						bit_cnt_ff <= 4'h0;
						state_ff <= ST_TX;
					end
				default:
					oe_n_ff <= 1'b1;
			endcase
		end
	end

	assign sda_out = 1'b0;
	assign sda_oe_n = oe_n_ff;

	// ==========================================================
	// Byte classification within a write
	always_ff @(posedge clk)
	begin
		if (!resetn || start)
		begin
			kind_ff <= K_FIRST;
			was_data_ff <= 1'b0;
		end
		else if (byte_done)
		begin
			was_data_ff <= kind_ff == K_DATA;
			case (kind_ff)
				K_FIRST: kind_ff <= is_addr ? K_DATA : K_SKIP;
				K_SKIP: kind_ff <= K_FIRST;
				default: kind_ff <= K_DATA;
			endcase
		end
	end

	// ==========================================================
	// Pointer and display RAM
	always_ff @(posedge clk)
	begin
		if (!resetn)
			ptr_ff <= RAM_FIRST;
		else if (byte_done && kind_ff == K_FIRST && is_addr)
			ptr_ff <= shift_ff[4:0];
		else if (ptr_inc)
			ptr_ff <= (ptr_ff >= RAM_LAST) ? RAM_FIRST
				: ptr_ff + 5'h1;
	end

	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			for (int i = 0; i < RAM_DEPTH; i++)
				ram[i] <= 8'h00;
		end
		else if (byte_done && kind_ff == K_DATA && ptr_ff <= RAM_LAST)
			ram[ptr_ff] <= shift_ff;
	end

	always_ff @(posedge clk)
	begin
		if (!resetn)
			disp_data_ff <= 8'h00;
		else
			disp_data_ff <= ram_rd(disp_addr);
	end

	assign disp_data = disp_data_ff;
	assign ram_pointer_bits = ptr_ff;

	// ==========================================================
	// Command registers; unknown codes fall through untouched
	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			bias_half <= MODE_RESET[MODE_M_BIT];
			frame_160hz <= MODE_RESET[MODE_F_BIT];
			osc_run <= MODE_RESET[MODE_S_BIT];
			mode_en_ff <= MODE_RESET[MODE_E_BIT];
			display_on <= 1'b0;
		end
		else if (byte_done && kind_ff == K_FIRST && is_mode)
		begin
			bias_half <= shift_ff[MODE_M_BIT];
			frame_160hz <= shift_ff[MODE_F_BIT];
			osc_run <= shift_ff[MODE_S_BIT];
			mode_en_ff <= shift_ff[MODE_E_BIT];
			display_on <= shift_ff[MODE_S_BIT]
				&& shift_ff[MODE_E_BIT];
		end
	end

	always_ff @(posedge clk)
	begin
		if (!resetn)
			blink_rate_bits <= BLINK_RESET;
		else if (byte_done && kind_ff == K_FIRST && is_blink)
			blink_rate_bits <= shift_ff[1:0];
	end

	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			pin_function_select <= TRIM_PIN_RESET;
			voltage_adjust_enable <= TRIM_ADJ_RESET;
			voltage_step_code <= TRIM_STEP_RESET;
			bias_follower_amp <= 1'b0;
		end
		else if (byte_done && kind_ff == K_FIRST && is_trim)
		begin
			pin_function_select <= shift_ff[TRIM_DE_BIT];
			voltage_adjust_enable <= shift_ff[TRIM_VE_BIT];
			voltage_step_code <= shift_ff[3:0];
			bias_follower_amp <= shift_ff[3:0] != 4'h0
				&& !(shift_ff[TRIM_DE_BIT]
				&& !shift_ff[TRIM_VE_BIT]);
		end
	end

	// ==========================================================
	// Blink timing
	blink_divider #(.DIV_BASE(DIV_BASE)) u_blink
	(
		.clk(clk),
		.resetn(resetn),
		.osc_run(osc_run),
		.rate(blink_rate_bits),
		.blink_blank(blink_blank)
	);

	// ==========================================================
	// Checks
	chk_addr_ack: assert property (@(posedge clk) disable iff (!resetn)
		state_ff == ST_ADDR && scl_fall && !start && !stop
		&& bit_cnt_ff == BYTE_BITS && shift_ff[7:1] == DEV_ADDR
		|=> !sda_oe_n && state_ff == ST_ADDR_ACK)
		else $error("matching address not acknowledged");
	chk_addr_miss: assert property (@(posedge clk) disable iff (!resetn)
		state_ff == ST_ADDR && scl_fall && !start && !stop
		&& bit_cnt_ff == BYTE_BITS && shift_ff[7:1] != DEV_ADDR
		|=> sda_oe_n && state_ff == ST_IDLE)
		else $error("foreign address taken");
	chk_stop_idle: assert property (@(posedge clk) disable iff (!resetn)
		stop |=> state_ff == ST_IDLE && sda_oe_n)
		else $error("bus held after stop");
	chk_ptr_wrap: assert property (@(posedge clk) disable iff (!resetn)
		ptr_inc && ptr_ff == RAM_LAST && !byte_done
		|=> ptr_ff == RAM_FIRST)
		else $error("pointer failed to wrap");
	chk_ptr_step: assert property (@(posedge clk) disable iff (!resetn)
		ptr_inc && ptr_ff < RAM_LAST
		|=> ptr_ff == $past(ptr_ff) + 5'h1)
		else $error("pointer step wrong");
	chk_read_step: assert property (@(posedge clk) disable iff (!resetn)
		state_ff == ST_TX_ACK && scl_rise && !sda_s && !start && !stop
		|=> ptr_ff != $past(ptr_ff))
		else $error("read pointer not advanced after acknowledge");
	chk_skip_nowr: assert property (@(posedge clk) disable iff (!resetn)
		byte_done && kind_ff == K_SKIP
		|=> $stable(ram_rd(ptr_ff)) && kind_ff == K_FIRST)
		else $error("discarded byte reached display RAM");
	chk_undef_keep: assert property (@(posedge clk) disable iff (!resetn)
		byte_done && kind_ff == K_FIRST && !is_addr && !is_mode
		&& !is_blink && !is_trim
		|=> $stable({bias_half, osc_run, display_on, blink_rate_bits,
		voltage_step_code, pin_function_select, ptr_ff}))
		else $error("undefined command changed settings");
	chk_blank_osc: assert property (@(posedge clk) disable iff (!resetn)
		!osc_run |-> !display_on)
		else $error("display on with oscillator stopped");
	chk_follow_off: assert property (@(posedge clk) disable iff (!resetn)
		pin_function_select && !voltage_adjust_enable
		|-> !bias_follower_amp)
		else $error("follower on in segment mode without adjust");
endmodule // lcd_command_slave
`default_nettype wire

// ---- verilog/lcd_cmd_pkg.sv ----
// Purpose: Shared constants and types of the LCD command slave.
// Assumes: One 10 MHz system clock, synchronous active-low reset.
// Notes: Blink divisor defaults live here; the top exposes them.
//
// Functional notes
// - First byte: address plus direction, 1 reads
// - Compare seven address bits with device address
// - Matching address gets acknowledge on ninth clock
// - Single write: address, pointer, data; all acknowledged
// - Byte after a command byte other than 000 is discarded
// - Writes store at pointer, advance after acknowledge
// - Pointer wraps from 15h to 00h
// - Read: set pointer, restart, data MSB first
// - Read pointer advances after master acknowledge clock
// - Reads continue on consecutive locations until STOP
// - Mode command 100: frame, osc, enable, bias
// - Bias bit 0 one-third, 1 one-half
// - Oscillator off blanks; both set shows display
// - Frame bit 0 gives 80Hz, 1 gives 160Hz
// - Reset: third bias, off, stopped, 80Hz
// - Undefined command bytes change nothing
// - Command 000 loads pointer; pointer resets 00h
// - Command 110000 sets blink; off at reset
// - Command 01: pin function, adjust, trim code
// - Pin bit picks supply or segment use
// - Trim zero or pin-adjust 10 disables follower
// - Reset: adjust off, shared pin supply mode
// - Blink divides clock by 16384, 32768, 65536
package lcd_cmd_pkg;
	// ==========================================================
	// Addressing
	localparam logic [6:0] DEV_ADDR = 7'h3f;
	localparam logic [4:0] RAM_FIRST = 5'h00;
	localparam logic [4:0] RAM_LAST = 5'h15;
	localparam int RAM_DEPTH = 22;
	localparam logic [3:0] BYTE_BITS = 4'h8;
	// ==========================================================
	// Command codes and field positions
	localparam logic [2:0] OP_ADDR = 3'h0;
	localparam logic [2:0] OP_MODE = 3'h4;
	localparam logic [5:0] OP_BLINK = 6'h30;
	localparam logic [1:0] OP_TRIM = 2'h1;
	localparam int MODE_F_BIT = 4;
	localparam int MODE_S_BIT = 3;
	localparam int MODE_E_BIT = 2;
	localparam int MODE_Z_BIT = 1;
	localparam int MODE_M_BIT = 0;
	localparam int TRIM_DE_BIT = 5;
	localparam int TRIM_VE_BIT = 4;
	// ==========================================================
	// Reset values
	localparam logic [7:0] MODE_RESET = 8'h80;
	localparam logic [1:0] BLINK_RESET = 2'h0;
	localparam logic TRIM_PIN_RESET = 1'b0;
	localparam logic TRIM_ADJ_RESET = 1'b0;
	localparam logic [3:0] TRIM_STEP_RESET = 4'h0;
	// ==========================================================
	// Timing: blink divisor of the fastest rate, in clock cycles
	localparam int BLINK_DIV_BASE = 16384;
	// ==========================================================
	// Types
	typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_RX,
		ST_RX_ACK, ST_TX, ST_TX_ACK} state_t;
	typedef enum logic [1:0] {K_FIRST, K_DATA, K_SKIP} kind_t;
endpackage

// ---- verilog/two_wire_sync.sv ----
// Purpose: Synchronise the bus pins and find edges, START and STOP.
// Assumes: Bus edges far slower than the system clock.
// Notes: Pulses are one clock wide.
`timescale 1ns/1ps
`default_nettype none
module two_wire_sync
(
	// Clock and reset
	input wire logic clk,
	input wire logic resetn,
	// Raw pins
	input wire logic scl_in,
	input wire logic sda_in,
	// Synchronised view
	output logic sda_s,
	output logic scl_rise,
	output logic scl_fall,
	output logic start,
	output logic stop
);
	// ==========================================================
	// Two-stage synchronisers plus one history stage
	logic [1:0] scl_sync_ff;
	logic [1:0] sda_sync_ff;
	logic scl_q_ff;
	logic sda_q_ff;

	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			scl_sync_ff <= 2'h3;
			sda_sync_ff <= 2'h3;
			scl_q_ff <= 1'b1;
			sda_q_ff <= 1'b1;
		end
		else
		begin
			scl_sync_ff <= {scl_sync_ff[0], scl_in};
			sda_sync_ff <= {sda_sync_ff[0], sda_in};
			scl_q_ff <= scl_sync_ff[1];
			sda_q_ff <= sda_sync_ff[1];
		end
	end

	assign sda_s = sda_sync_ff[1];
	assign scl_rise = scl_sync_ff[1] && !scl_q_ff;
	assign scl_fall = !scl_sync_ff[1] && scl_q_ff;
	// Data moving while the clock stays high marks a frame boundary.
	assign start = scl_sync_ff[1] && scl_q_ff && sda_q_ff && !sda_s;
	assign stop = scl_sync_ff[1] && scl_q_ff && !sda_q_ff && sda_s;

	chk_edges_excl: assert property (@(posedge clk) disable iff (!resetn)
		start |-> !stop && !scl_rise && !scl_fall)
		else $error("frame mark together with clock edge");
endmodule // two_wire_sync
`default_nettype wire

// ---- verilog/blink_divider.sv ----
// Purpose: Blink phase generator from the system clock.
// Assumes: Counts only while the oscillator runs.
// Notes: Phase toggles every half of the selected period.
`timescale 1ns/1ps
`default_nettype none
module blink_divider
	import lcd_cmd_pkg::*;
#(
	parameter int DIV_BASE = BLINK_DIV_BASE
)
(
	// Clock and reset
	input wire logic clk,
	input wire logic resetn,
	// Control
	input wire logic osc_run,
	input wire logic [1:0] rate,
	// Phase out, high while the display is blanked
	output logic blink_blank
);
	// ==========================================================
	// Half-period limits for the three rates
	localparam int HALF = DIV_BASE / 2;
	logic [17:0] cnt_ff;
	logic [17:0] limit;

	always_comb
	begin
		case (rate)
			2'h1: limit = 18'(HALF);
			2'h2: limit = 18'(HALF * 2);
			default: limit = 18'(HALF * 4);
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (!resetn || rate == BLINK_RESET || !osc_run)
		begin
			cnt_ff <= 18'h0;
			blink_blank <= 1'b0;
		end
		// A faster rate picked after its limit has passed ends the phase at once.
		else if (cnt_ff >= limit - 18'h1)
		begin
			cnt_ff <= 18'h0;
			blink_blank <= !blink_blank;
		end
		else
			cnt_ff <= cnt_ff + 18'h1;
	end

	chk_blink_off: assert property (@(posedge clk) disable iff (!resetn)
		rate == BLINK_RESET |=> !blink_blank)
		else $error("blink phase active with blinking off");
endmodule // blink_divider
`default_nettype wire

// ---- verification/two_wire_host.sv ----
// Purpose: Two-wire bus master model that drives the LCD command slave.
// Assumes: Open-drain data line with a pull-up; 20 clocks per bus bit.
// Notes: Pins change by non-blocking assignment at rising clock edges.
`timescale 1ns/1ps
`default_nettype none
module two_wire_host
(
	// Clock
	input wire logic clk,
	// Bus
	output logic scl,
	output logic sda_low,
	input wire logic sda_line
);
	// ==========================================================
	// Bit timing
	initial
	begin
		scl = 1'b1;
		sda_low = 1'b0;
	end

	task automatic hold(input int n);
		repeat (n) @(posedge clk);
	endtask

	// Data moves two clocks after the clock falls, so the slave's
	// synchroniser never sees both pins change in the same cycle.
	task automatic bit_io(input logic drv, output logic seen);
		hold(2);
		sda_low <= ~drv;
		hold(8);
		scl <= 1'b1;
		hold(10);
		seen = sda_line;
		scl <= 1'b0;
	endtask

	// ==========================================================
	// Framing
	// The clock may have been lowered by a pending update in this very
	// time step, so let one edge pass before looking at it; otherwise a
	// repeated START would be skipped.
	task automatic bus_start();
		hold(1);
		if (scl == 1'b0)
		begin
			hold(2);
			sda_low <= 1'b0;
			hold(8);
			scl <= 1'b1;
		end
		hold(10);
		sda_low <= 1'b1;
		hold(10);
		scl <= 1'b0;
	endtask

	task automatic bus_stop();
		hold(2);
		sda_low <= 1'b1;
		hold(8);
		scl <= 1'b1;
		hold(10);
		sda_low <= 1'b0;
		hold(10);
	endtask

	task automatic send_byte(input logic [7:0] b, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--)
			bit_io(b[i], s);
		bit_io(1'b1, ack);
	endtask

	task automatic recv_byte(input logic nack, output logic [7:0] b);
		logic s;
		for (int i = 7; i >= 0; i--)
		begin
			bit_io(1'b1, s);
			b[i] = s;
		end
		bit_io(nack, s);
	endtask
endmodule // two_wire_host
`default_nettype wire

// ---- verification/test_lcd_command_slave.sv ----
// Purpose: Self-checking bench of the LCD command slave.
// Assumes: Blink divisor shortened to 16 clocks.
// Notes: Expected settings pack bias..follower into one vector.
`timescale 1ns/1ps
`default_nettype none
module test_lcd_command_slave
	import lcd_cmd_pkg::*;
;
	localparam int DIV = 16;
	logic clk;
	logic resetn;
	logic scl;
	logic sda_low;
	logic sda_line;
	logic [4:0] disp_addr;
	logic sda_out;
	logic sda_oe_n;
	logic [7:0] disp_data;
	logic bias_half;
	logic frame_160hz;
	logic osc_run;
	logic display_on;
	logic [1:0] blink_rate_bits;
	logic blink_blank;
	logic pin_function_select;
	logic voltage_adjust_enable;
	logic [3:0] voltage_step_code;
	logic bias_follower_amp;
	logic [4:0] ram_pointer_bits;
	logic [12:0] settings;
	logic ack;
	logic [7:0] rd;
	int n_errors = 0;
	int checks = 0;
	logic [7:0] cmd_tab [12] = '{8'h9d, 8'h88, 8'h97, 8'hc1, 8'hc3, 8'hc2,
		8'h5f, 8'h6f, 8'h74, 8'h40, 8'h84, 8'hc0};
	logic [12:0] exp_tab [12] = '{13'h1e00, 13'h0400, 13'h0400, 13'h0480,
		13'h0580, 13'h0500, 13'h053f, 13'h055e, 13'h0569, 13'h0500,
		13'h0100, 13'h0000};
	int half_tab [12] = '{0, 0, 0, 8, 32, 16, 0, 0, 0, 0, 0, 0};

	// Open-drain wire: a pull-up wins unless either party pulls low.
	assign sda_line = ~(sda_low | (~sda_oe_n & ~sda_out));
	assign settings = {bias_half, frame_160hz, osc_run, display_on,
		blink_rate_bits, pin_function_select, voltage_adjust_enable,
		voltage_step_code, bias_follower_amp};

	initial
		clk = 1'b0;
	always
		#50 clk = ~clk;

	lcd_command_slave #(.DIV_BASE(DIV)) dut (
		.clk(clk), .resetn(resetn), .scl_in(scl), .sda_in(sda_line),
		.sda_out(sda_out), .sda_oe_n(sda_oe_n), .disp_addr(disp_addr),
		.disp_data(disp_data), .bias_half(bias_half),
		.frame_160hz(frame_160hz), .osc_run(osc_run),
		.display_on(display_on), .blink_rate_bits(blink_rate_bits),
		.blink_blank(blink_blank), .pin_function_select(pin_function_select),
		.voltage_adjust_enable(voltage_adjust_enable),
		.voltage_step_code(voltage_step_code),
		.bias_follower_amp(bias_follower_amp),
		.ram_pointer_bits(ram_pointer_bits));

	two_wire_host host (.clk(clk), .scl(scl), .sda_low(sda_low),
		.sda_line(sda_line));

	// ==========================================================
	// Checking and access tasks
	task automatic check(input string what, input logic [15:0] seen,
		input logic [15:0] exp);
		checks++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("wrong value %s: expected %h, seen %h", what, exp, seen);
		end
	endtask

	task automatic finish_test();
		$display("checks %0d, n_errors %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	task automatic write_bytes(input logic [7:0] q[$]);
		host.bus_start();
		host.send_byte({DEV_ADDR, 1'b0}, ack);
		check("address ack", 16'(ack), 16'h0000);
		foreach (q[i])
		begin
			host.send_byte(q[i], ack);
			check("byte ack", 16'(ack), 16'h0000);
		end
		host.bus_stop();
	endtask

	// The read port has one register stage, so the third edge is safe.
	task automatic peek(input logic [4:0] a, input logic [7:0] exp);
		disp_addr <= a;
		repeat (3) @(posedge clk);
		check("display byte", 16'(disp_data), 16'(exp));
	endtask

	task automatic blink_half(input int n);
		int w;
		int hi;
		w = 0;
		hi = 0;
		while (blink_blank !== 1'b0 && w < 300)
		begin
			@(posedge clk);
			w++;
		end
		while (blink_blank !== 1'b1 && w < 300)
		begin
			@(posedge clk);
			w++;
		end
		while (blink_blank === 1'b1 && hi < 300)
		begin
			@(posedge clk);
			hi++;
		end
		check("blink half period", 16'(hi), 16'(n));
	endtask

	// ==========================================================
	// Watchdog, far beyond the roughly 10000 cycles the tests need
	initial
	begin
		repeat (60000) @(posedge clk);
		n_errors++;
		finish_test();
	end

	// ==========================================================
	// Tests
	initial
	begin
		resetn = 1'b0;
		disp_addr = 5'h00;
		repeat (16) @(posedge clk);
		resetn <= 1'b1;
		repeat (4) @(posedge clk);
		check("settings", 16'(settings), 16'h0000);
		check("pointer", 16'(ram_pointer_bits), 16'h0000);
		check("data enable", 16'(sda_oe_n), 16'h0001);
		foreach (cmd_tab[i])
			if (i < 2)
			begin
				host.bus_start();
				host.send_byte(i == 0 ? 8'h7c : 8'hfe, ack);
				check("foreign ack", 16'(ack), 16'h0001);
				host.send_byte(8'h05, ack);
				check("ignored ack", 16'(ack), 16'h0001);
				host.bus_stop();
			end
		check("pointer", 16'(ram_pointer_bits), 16'h0000);
		write_bytes('{8'h14, 8'ha5, 8'h5a, 8'h3c});
		check("pointer", 16'(ram_pointer_bits), 16'h0001);
		peek(5'h14, 8'ha5);
		peek(5'h15, 8'h5a);
		peek(5'h00, 8'h3c);
		host.bus_start();
		host.send_byte({DEV_ADDR, 1'b0}, ack);
		host.send_byte(8'h15, ack);
		host.bus_start();
		host.send_byte({DEV_ADDR, 1'b1}, ack);
		check("read ack", 16'(ack), 16'h0000);
		host.recv_byte(1'b0, rd);
		check("read byte", 16'(rd), 16'h005a);
		check("pointer", 16'(ram_pointer_bits), 16'h0000);
		host.recv_byte(1'b0, rd);
		check("read byte", 16'(rd), 16'h003c);
		host.recv_byte(1'b1, rd);
		check("read byte", 16'(rd), 16'h0000);
		host.bus_stop();
		check("pointer", 16'(ram_pointer_bits), 16'h0001);
		foreach (cmd_tab[i])
		begin
			write_bytes('{cmd_tab[i], 8'h0a});
			check("settings", 16'(settings), 16'(exp_tab[i]));
			check("pointer", 16'(ram_pointer_bits), 16'h0001);
			if (half_tab[i] != 0)
				blink_half(half_tab[i]);
			if (i == 10)
				check("blink phase", 16'(blink_blank), 16'h0000);
		end
		finish_test();
	end
endmodule // test_lcd_command_slave
`default_nettype wire
